// ### rtl/col_cam_output.sv
// Cam output option logic: direction cams, time cams, speed display, locking, braking
`timescale 1ns/1ns
// Overview of operation
// R01: Speed shown binary on top eight outputs
// R02: Speed above 255 displayed as 255
// R03: Per-output direction: both, positive, negative
// R04: Limited outputs switch only on matching edges
// R05: First cycle after change updates all
// R06: Time cam: on at position, off after duration
// R07: Reject time cam if on equals duration
// R08: Time cams get no delay compensation
// R09: Capacity 1000 records, 1500 when expanded
// R10: Upper locked outputs need program unlock
// R11: Program controller counts from internal timebase
// R12: Strict check faults deltas beyond one
// R13: Fault counter down, weighted up, 256 errors
// R14: Fast option: outputs 1-8 direct compensation
// R15: Clear resets count when preset select low
// R16: Clear loads preset when preset select high
// R17: Preset defaults zero, later changeable
// R18: Password 0815 guards locks and clear-all
// R19: Brake angle accumulated until speed zero
// R20: Measured angle flashes ten seconds
// R21: Angle over maximum: error 29, relay off
// R22: Escape clears brake error, re-arms measuring
// R23: Wide serial encoder uses single-turn bits
// R24: Direction from sign of position difference
module col_cam_output #(
	parameter int NUM_OUT    = 24,
	parameter int ST_W       = 12,
	parameter bit EXP_MEM    = 1'b0,
	parameter int CYC_PER_MS = col_pkg::CYC_PER_MS
) (
	// Clock and reset
	input  wire logic                       clock,
	input  wire logic                       rstn,
	// Option and mode configuration
	input  wire col_pkg::col_opt_t          opt,
	input  wire logic [7:0]                 lock_count,
	input  wire logic [6:0]                 fault_weight_step,
	input  wire logic [15:0]                timebase_ms,
	input  wire logic [6:0]                 brake_max_angle,
	// Position sources
	input  wire logic                       enc_valid,
	input  wire logic [15:0]                enc_pos,
	input  wire logic [col_pkg::SER_W-1:0]  ser_pos,
	input  wire logic                       inc_step,
	input  wire logic                       inc_down,
	input  wire logic                       count_clear,
	input  wire logic                       preset_select_input,
	input  wire logic [15:0]                speed,
	// Program and initialization access
	input  wire logic                       cam_we,
	input  wire logic [7:0]                 cam_idx,
	input  wire col_pkg::col_cam_t          cam_data,
	input  wire logic                       clear_all,
	input  wire logic                       preset_we,
	input  wire logic [15:0]                preset_value,
	input  wire logic                       program_unlock,
	input  wire logic                       pw_enter,
	input  wire logic [15:0]                pw_value,
	input  wire logic                       brake_cmd,
	input  wire logic                       esc_key,
	// Outputs
	output logic [NUM_OUT-1:0]              cam_out,
	output logic [NUM_OUT-1:0]              delay_compensation,
	output logic [NUM_OUT-1:0]              direct_compensation,
	output logic [15:0]                     position,
	output logic                            dir_negative,
	output logic [7:0]                      error_code,
	output logic                            write_reject,
	output logic                            store_full,
	output logic [15:0]                     brake_angle,
	output logic                            brake_flash,
	output logic                            run_relay
);
	localparam int REC_CAP = EXP_MEM ? col_pkg::REC_EXP : col_pkg::REC_BASE;
	localparam logic [10:0] REC_CAP_V = 11'(REC_CAP);
	localparam logic [16:0] MS_LAST = 17'(CYC_PER_MS - 1);
	localparam logic [13:0] SHOW_LAST = 14'(col_pkg::BRAKE_SHOW_MS - 1);

	col_pkg::col_cam_t cam_mem [NUM_OUT];
	col_pkg::col_brk_t brk_reg, brk_next;
	logic [16:0]        ms_cnt_reg, ms_cnt_next;
	logic [15:0]        tb_cnt_reg, tb_cnt_next;
	logic [15:0]        cnt_reg, cnt_next;
	logic [15:0]        pos_reg, pos_next, prev_reg;
	logic [15:0]        preset_reg, preset_next;
	logic [15:0]        enc_last_reg, enc_last_next;
	logic [9:0]         fault_reg, fault_next;
	logic               enc_err_reg, enc_err_next;
	logic               neg_reg, neg_next;
	logic               first_reg, first_next;
	logic               pw_ok_reg, pw_ok_next;
	logic               t22_reg, t22_next;
	logic               rej_reg, rej_next;
	logic [10:0]        rec_reg, rec_next;
	logic [15:0]        ang_reg, ang_next;
	logic [13:0]        show_reg, show_next;
	logic               brk_err_reg, brk_err_next;
	logic               brake_d_reg;
	logic [NUM_OUT-1:0] out_q;
	logic               ms_tick, tb_tick;
	logic [15:0]        abs_pos;
	logic signed [16:0] delta, enc_delta;
	logic [16:0]        enc_mag, pos_mag;
	logic               wr_ok, lock_ok, locked, cam_bad;
	logic [7:0]         spd8;

	// Millisecond and program-controller time bases
	always_comb
	begin
		ms_tick = (ms_cnt_reg == MS_LAST);
		ms_cnt_next = ms_tick ? 17'h00000 : ms_cnt_reg + 17'h00001;
		tb_tick = 1'b0;
		tb_cnt_next = tb_cnt_reg;
		if (ms_tick)
		begin
			// A setting below the minimum runs as the minimum, one tick per millisecond
			tb_tick = (tb_cnt_reg + 16'h0001 >= ((timebase_ms < col_pkg::TB_MIN) ?
				col_pkg::TB_MIN : timebase_ms));
			tb_cnt_next = tb_tick ? 16'h0000 : tb_cnt_reg + 16'h0001;
		end
	end

	// Position selection and counting
	always_comb
	begin
		// R23: single-turn bits only
		abs_pos = opt.wide_serial_encoder_option ? 16'(ser_pos[ST_W-1:0]) : enc_pos;
		cnt_next = cnt_reg;
		preset_next = preset_we ? preset_value : preset_reg;
		if (opt.inc_mode || opt.prog_ctrl_mode)
		begin
			if (count_clear)
			begin
				// R16: preset loaded on clear
				if (opt.preset_on_clear_option && preset_select_input)
					cnt_next = preset_reg;
				// R15: clear to zero
				else
					cnt_next = 16'h0000;
			end
			// R11: internal timebase advances count
			else if (opt.prog_ctrl_mode)
				cnt_next = cnt_reg + 16'(tb_tick);
			else if (inc_step)
				cnt_next = inc_down ? cnt_reg - 16'h0001 : cnt_reg + 16'h0001;
		end
		pos_next = pos_reg;
		if (opt.inc_mode || opt.prog_ctrl_mode)
			pos_next = cnt_reg;
		else if (enc_valid)
			pos_next = abs_pos;
		// R24: direction from difference sign
		delta = $signed({1'b0, pos_reg}) - $signed({1'b0, prev_reg});
		neg_next = (delta < 0) ? 1'b1 : ((delta > 0) ? 1'b0 : neg_reg);
		pos_mag = delta[16] ? 17'(-delta) : 17'(delta);
	end

	// Encoder plausibility monitor
	always_comb
	begin
		enc_delta = $signed({1'b0, abs_pos}) - $signed({1'b0, enc_last_reg});
		enc_mag = enc_delta[16] ? 17'(-enc_delta) : 17'(enc_delta);
		enc_last_next = enc_valid ? abs_pos : enc_last_reg;
		fault_next = fault_reg;
		enc_err_next = enc_err_reg;
		if (enc_valid && !opt.inc_mode && !opt.prog_ctrl_mode)
		begin
			// R12: strict limit of one increment
			if (enc_mag > (opt.strict_encoder_check_option ? col_pkg::STRICT_DELTA :
				col_pkg::NORMAL_DELTA))
				// R13: weighted count up
				fault_next = (fault_reg + 10'(fault_weight_step) >= col_pkg::FAULT_LIMIT) ?
					col_pkg::FAULT_LIMIT : fault_reg + 10'(fault_weight_step);
			// R13: count down on good sample
			else if (fault_reg != 10'h000)
				fault_next = fault_reg - 10'h001;
		end
		// R13: error at limit, held until reset
		if (fault_next >= col_pkg::FAULT_LIMIT)
			enc_err_next = 1'b1;
	end

	// Program access, locking and password
	always_comb
	begin
		// R18: password latch
		pw_ok_next = pw_enter ? (pw_value == col_pkg::PASSWORD) : pw_ok_reg;
		// R10: upper outputs locked
		locked = (32'(cam_idx) >= NUM_OUT - 32'(lock_count));
		// R18: password also needed when fitted
		lock_ok = program_unlock && (!opt.password_lock_option || pw_ok_reg);
		// R07: time cam with on equal duration
		cam_bad = cam_data.time_mode && ((cam_data.on_pos == cam_data.off_val) ||
			(cam_data.off_val < col_pkg::DUR_MIN) || (cam_data.off_val > col_pkg::DUR_MAX));
		// R09: record capacity check
		store_full = (rec_reg >= REC_CAP_V);
		wr_ok = cam_we && (32'(cam_idx) < NUM_OUT) && (!locked || lock_ok) && !cam_bad &&
			!store_full;
		rej_next = cam_we && !wr_ok;
		rec_next = rec_reg + 11'(wr_ok);
		t22_next = t22_reg;
		if (wr_ok)
			t22_next = 1'b0;
		// Set wins over clear
		if (cam_we && cam_data.time_mode && (cam_data.on_pos == cam_data.off_val))
			t22_next = 1'b1;
		first_next = 1'b0;
		// R18: clear-all guarded by password
		if (clear_all && (!opt.password_lock_option || pw_ok_reg))
		begin
			rec_next = 11'h000;
			first_next = 1'b1;
		end
		// R05: program change forces full update
		if (wr_ok)
			first_next = 1'b1;
	end

	// Braking angle measurement
	always_comb
	begin
		brk_next = brk_reg;
		ang_next = ang_reg;
		show_next = show_reg;
		brk_err_next = brk_err_reg;
		case (brk_reg)
			col_pkg::COL_BRK_IDLE:
			begin
				if (opt.brake_angle_option && brake_cmd && !brake_d_reg && !brk_err_reg)
				begin
					brk_next = col_pkg::COL_BRK_MEAS;
					ang_next = 16'h0000;
				end
			end
			col_pkg::COL_BRK_MEAS:
			begin
				// R19: accumulate until standstill
				if (speed == 16'h0000)
				begin
					brk_next = col_pkg::COL_BRK_SHOW;
					show_next = 14'h0000;
					// R21: limit exceeded
					if (ang_reg > 16'(brake_max_angle))
						brk_err_next = 1'b1;
				end
				else
					ang_next = (32'(ang_reg) + 32'(pos_mag) > 32'h0000ffff) ? 16'hffff :
						ang_reg + 16'(pos_mag);
			end
			col_pkg::COL_BRK_SHOW:
			begin
				// R20: ten second flashing display
				if (ms_tick)
				begin
					show_next = show_reg + 14'h0001;
					if (show_reg == SHOW_LAST)
						brk_next = col_pkg::COL_BRK_IDLE;
				end
			end
			default:
				brk_next = col_pkg::COL_BRK_IDLE;
		endcase
		// R22: escape clears and re-arms
		if (esc_key && brk_err_reg)
		begin
			brk_err_next = 1'b0;
			brk_next = col_pkg::COL_BRK_IDLE;
		end
	end

	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			ms_cnt_reg <= 17'h00000;
			tb_cnt_reg <= 16'h0000;
			cnt_reg <= col_pkg::POS_RESET;
			pos_reg <= col_pkg::POS_RESET;
			prev_reg <= col_pkg::POS_RESET;
			// R17: preset defaults to zero
			preset_reg <= col_pkg::PRESET_RESET;
			enc_last_reg <= col_pkg::POS_RESET;
			fault_reg <= col_pkg::FAULT_RESET;
			enc_err_reg <= 1'b0;
			neg_reg <= 1'b0;
			// R05: first cycle after power-up
			first_reg <= 1'b1;
			pw_ok_reg <= 1'b0;
			t22_reg <= 1'b0;
			rej_reg <= 1'b0;
			rec_reg <= 11'h000;
			brk_reg <= col_pkg::COL_BRK_IDLE;
			ang_reg <= 16'h0000;
			show_reg <= 14'h0000;
			brk_err_reg <= 1'b0;
			brake_d_reg <= 1'b0;
		end
		else
		begin
			ms_cnt_reg <= ms_cnt_next;
			tb_cnt_reg <= tb_cnt_next;
			cnt_reg <= cnt_next;
			pos_reg <= pos_next;
			prev_reg <= pos_reg;
			preset_reg <= preset_next;
			enc_last_reg <= enc_last_next;
			fault_reg <= fault_next;
			enc_err_reg <= enc_err_next;
			neg_reg <= neg_next;
			first_reg <= first_next;
			pw_ok_reg <= pw_ok_next;
			t22_reg <= t22_next;
			rej_reg <= rej_next;
			rec_reg <= rec_next;
			brk_reg <= brk_next;
			ang_reg <= ang_next;
			show_reg <= show_next;
			brk_err_reg <= brk_err_next;
			brake_d_reg <= brake_cmd;
		end
	end

	// R02: saturate speed at 255
	assign spd8 = (speed > col_pkg::SPD_MAX) ? 8'hff : speed[7:0];

	// Per-output cam evaluation
	genvar gi;
	generate
		for (gi = 0; gi < NUM_OUT; gi++)
		begin : g_out
			col_pkg::col_cam_t cam_next;
			logic              q_reg, q_next, lvl_prev_reg, lvl;
			logic [15:0]       tmr_reg, tmr_next;
			logic              on_hit, dir_ok, fin;

			always_comb
			begin
				cam_next = (wr_ok && (32'(cam_idx) == gi)) ? cam_data : cam_mem[gi];
				if (cam_mem[gi].on_pos <= cam_mem[gi].off_val)
					lvl = (pos_reg >= cam_mem[gi].on_pos) && (pos_reg < cam_mem[gi].off_val);
				else
					lvl = (pos_reg >= cam_mem[gi].on_pos) || (pos_reg < cam_mem[gi].off_val);
				on_hit = (pos_reg == cam_mem[gi].on_pos) && (prev_reg != cam_mem[gi].on_pos);
				// R03: three direction choices
				case (cam_mem[gi].dir)
					col_pkg::COL_DIR_POS: dir_ok = !neg_next;
					col_pkg::COL_DIR_NEG: dir_ok = neg_next;
					default:              dir_ok = 1'b1;
				endcase
				q_next = q_reg;
				tmr_next = tmr_reg;
				if (cam_mem[gi].time_mode)
				begin
					// R06: on at position, off after duration
					fin = (tmr_reg + 16'h0001 >= cam_mem[gi].off_val);
					if (on_hit && (dir_ok || first_reg))
					begin
						q_next = 1'b1;
						tmr_next = 16'h0000;
					end
					else if (q_reg && ms_tick)
					begin
						tmr_next = tmr_reg + 16'h0001;
						if (fin)
							q_next = 1'b0;
					end
				end
				else
				begin
					fin = 1'b0;
					// R05: full update in first cycle
					if (first_reg)
						q_next = lvl;
					// R04: edge with matching direction
					else if ((lvl != lvl_prev_reg) && dir_ok)
						q_next = lvl;
				end
			end

			always_ff @(posedge clock or negedge rstn)
			begin
				if (!rstn)
				begin
					cam_mem[gi] <= '0;
					q_reg <= 1'b0;
					lvl_prev_reg <= 1'b0;
					tmr_reg <= 16'h0000;
				end
				else
				begin
					cam_mem[gi] <= cam_next;
					q_reg <= q_next;
					lvl_prev_reg <= lvl;
					tmr_reg <= tmr_next;
				end
			end

			always_comb
			begin
				// R01: speed bits on top outputs, MSB highest
				if (opt.speed_display && (gi >= NUM_OUT - col_pkg::SPD_BITS))
					out_q[gi] = spd8[3'(gi - (NUM_OUT - col_pkg::SPD_BITS))];
				else
					out_q[gi] = q_reg;
			end
		end
	endgenerate

	// Registered outputs; compensation steering is static per output
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			cam_out <= '0;
			delay_compensation <= '0;
			direct_compensation <= '0;
		end
		else
		begin
			cam_out <= out_q;
			for (int i = 0; i < NUM_OUT; i++)
			begin
				// R08: no delay compensation on time cams
				delay_compensation[i] <= !cam_mem[i].time_mode;
				// R14: first eight outputs direct method
				direct_compensation[i] <= opt.fast_compensation_option &&
					(i < col_pkg::FAST_OUTS);
			end
		end
	end

	always_comb
	begin
		position = pos_reg;
		dir_negative = neg_reg;
		write_reject = rej_reg;
		brake_angle = ang_reg;
		brake_flash = (brk_reg == col_pkg::COL_BRK_SHOW);
		// R21: relay drops on brake error
		run_relay = !brk_err_reg;
		if (enc_err_reg)
			error_code = col_pkg::ERR_ENCODER;
		else if (brk_err_reg)
			error_code = col_pkg::ERR_BRAKE;
		else if (t22_reg)
			error_code = col_pkg::ERR_TIME_CAM;
		else
			error_code = col_pkg::ERR_NONE;
	end
endmodule

// ### rtl/col_pkg.sv
// Shared constants and types for the cam output option logic
package col_pkg;
	// Clock and time base
	localparam int CLK_NS        = 8;
	localparam int NS_PER_MS     = 1_000_000;
	localparam int MS_PER_S      = 1000;
	localparam int CYC_PER_MS    = (NS_PER_MS + CLK_NS - 1) / CLK_NS;
	localparam int BRAKE_SHOW_S  = 10;
	localparam int BRAKE_SHOW_MS = BRAKE_SHOW_S * MS_PER_S;
	// Widths
	localparam int POS_W         = 16;
	localparam int SER_W         = 24;
	localparam int SPD_BITS      = 8;
	localparam int FAST_OUTS     = 8;
	// Speed display saturation
	localparam logic [15:0] SPD_MAX       = 16'h00ff;
	// Encoder plausibility
	localparam logic [16:0] NORMAL_DELTA  = 17'h00003;
	localparam logic [16:0] STRICT_DELTA  = 17'h00001;
	localparam logic [9:0]  FAULT_LIMIT   = 10'h100;
	localparam logic [9:0]  FAULT_RESET   = 10'h000;
	// Error codes
	localparam logic [7:0]  ERR_NONE      = 8'h00;
	localparam logic [7:0]  ERR_TIME_CAM  = 8'h16;
	localparam logic [7:0]  ERR_BRAKE     = 8'h1d;
	localparam logic [7:0]  ERR_ENCODER   = 8'h69;
	// Angle-time cam duration range in ms
	localparam logic [15:0] DUR_MIN       = 16'h0001;
	localparam logic [15:0] DUR_MAX       = 16'h7ef4;
	// Internal timebase period range in ms
	localparam logic [15:0] TB_MIN        = 16'h0001;
	// Braking angle limit setting
	localparam logic [6:0]  BRAKE_MAX_LIM = 7'h63;
	// Fixed password
	localparam logic [15:0] PASSWORD      = 16'h0815;
	// Record capacity
	localparam int REC_BASE      = 1000;
	localparam int REC_EXP       = 1500;
	// Reset values
	localparam logic [15:0] PRESET_RESET  = 16'h0000;
	localparam logic [15:0] POS_RESET     = 16'h0000;

	typedef enum logic [1:0]
	{
		COL_DIR_BOTH = 2'b00,
		COL_DIR_POS  = 2'b01,
		COL_DIR_NEG  = 2'b10
	} col_dir_t;

	typedef enum logic [1:0]
	{
		COL_BRK_IDLE = 2'b00,
		COL_BRK_MEAS = 2'b01,
		COL_BRK_SHOW = 2'b10
	} col_brk_t;

	// One cam record; off_val is the off position or, for time cams, the duration
	typedef struct packed
	{
		logic [15:0] on_pos;
		logic [15:0] off_val;
		col_dir_t    dir;
		logic        time_mode;
	} col_cam_t;

	typedef struct packed
	{
		logic speed_display;
		logic strict_encoder_check_option;
		logic fast_compensation_option;
		logic preset_on_clear_option;
		logic password_lock_option;
		logic brake_angle_option;
		logic wide_serial_encoder_option;
		logic inc_mode;
		logic prog_ctrl_mode;
	} col_opt_t;
endpackage

// ### sim/col_enc_model.sv
// Shaft encoder model stepping toward a commanded target
`timescale 1ns/1ns
module col_enc_model (
	// Clock and reset
	input	wire logic		clock,
	input	wire logic		rstn,
	// Motion command
	input	wire logic [15:0]	target,
	input	wire logic		coarse,
	// Encoder side
	output	logic			enc_valid,
	output	logic [15:0]		enc_pos
);
	logic [15:0]	pos_reg;
	logic [15:0]	step;
	logic		phase_reg;
	always @(negedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			pos_reg = 16'h0000;
			phase_reg = 1'b0;
			enc_valid = 1'b0;
			enc_pos = 16'hffff;
		end
		else
		begin
			// Coarse steps of two provoke plausibility faults only under the strict encoder check
			step = (coarse && (target > pos_reg + 16'h0001 || pos_reg > target + 16'h0001))
				? 16'h0002 : 16'h0001;
			if (phase_reg && target > pos_reg)
				pos_reg = pos_reg + step;
			else if (phase_reg && target < pos_reg)
				pos_reg = pos_reg - step;
			enc_valid = phase_reg;
			// Word not held between samples
			enc_pos = phase_reg ? pos_reg : ~pos_reg;
			phase_reg = ~phase_reg;
		end
	end
endmodule

// ### sim/col_cam_output_monitor.sv
// Port checker for the cam output option logic
`timescale 1ns/1ns
module col_cam_output_monitor #(
	parameter int NUM_OUT = 24
) (
	// Clock and reset
	input	wire logic			clock,
	input	wire logic			rstn,
	// Watched inputs
	input	wire col_pkg::col_opt_t		opt,
	input	wire logic [7:0]		lock_count,
	input	wire logic [15:0]		speed,
	input	wire logic			cam_we,
	input	wire logic [7:0]		cam_idx,
	input	wire col_pkg::col_cam_t		cam_data,
	input	wire logic			program_unlock,
	input	wire logic			count_clear,
	input	wire logic			preset_select_input,
	// Watched outputs
	input	wire logic [NUM_OUT-1:0]	cam_out,
	input	wire logic [NUM_OUT-1:0]	direct_compensation,
	input	wire logic [15:0]		position,
	input	wire logic			dir_negative,
	input	wire logic [7:0]		error_code,
	input	wire logic			write_reject,
	input	wire logic			brake_flash,
	input	wire logic			run_relay
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rstn);
	// Held settings give the registers time to follow
	sequence s_spd_held;
		(opt.speed_display && $stable(speed)) [*4];
	endsequence
	sequence s_fast_held;
		opt.fast_compensation_option [*3];
	endsequence
	property p_spd_bin;
		s_spd_held |-> (speed > col_pkg::SPD_MAX) || (cam_out[NUM_OUT-1 -: 8] == speed[7:0]);
	endproperty
	property p_spd_sat;
		s_spd_held ##0 (speed > col_pkg::SPD_MAX) |-> cam_out[NUM_OUT-1 -: 8] == 8'hff;
	endproperty
	property p_fast_map;
		s_fast_held |-> direct_compensation == {{(NUM_OUT-8){1'b0}}, 8'hff};
	endproperty
	property p_rej_cause;
		write_reject |-> $past(cam_we);
	endproperty
	property p_lock_ref;
		cam_we && cam_idx < NUM_OUT && cam_idx >= NUM_OUT - lock_count && !program_unlock
			|=> write_reject;
	endproperty
	property p_time_eq;
		cam_we && cam_data.time_mode && cam_data.on_pos == cam_data.off_val
			|=> write_reject && error_code != col_pkg::ERR_NONE;
	endproperty
	property p_enc_sticky;
		error_code == col_pkg::ERR_ENCODER |=> error_code == col_pkg::ERR_ENCODER;
	endproperty
	property p_relay_off;
		$fell(run_relay) |-> ##[0:2] (brake_flash && error_code != col_pkg::ERR_NONE);
	endproperty
	property p_clear_zero;
		opt.inc_mode && count_clear && !(opt.preset_on_clear_option && preset_select_input)
			|-> ##2 position == 16'h0000;
	endproperty
	property p_dir_up;
		position > $past(position) |-> ##[1:2] !dir_negative;
	endproperty
	a_spd_bin: assert property (p_spd_bin) else $error("speed bits wrong");
	a_spd_sat: assert property (p_spd_sat) else $error("speed not saturated");
	a_fast_map: assert property (p_fast_map) else $error("direct map wrong");
	a_rej_cause: assert property (p_rej_cause) else $error("reject without write");
	a_lock_ref: assert property (p_lock_ref) else $error("locked write taken");
	a_time_eq: assert property (p_time_eq) else $error("time cam not refused");
	a_enc_sticky: assert property (p_enc_sticky) else $error("encoder error lost");
	a_relay_off: assert property (p_relay_off) else $error("relay drop unexplained");
	a_clear_zero: assert property (p_clear_zero) else $error("clear not zero");
	a_dir_up: assert property (p_dir_up) else $error("direction wrong");
endmodule
bind col_cam_output col_cam_output_monitor #(.NUM_OUT(NUM_OUT)) u_mon (.clock, .rstn, .opt,
	.lock_count, .speed, .cam_we, .cam_idx, .cam_data, .program_unlock, .count_clear,
	.preset_select_input, .cam_out, .direct_compensation, .position, .dir_negative,
	.error_code, .write_reject, .brake_flash, .run_relay);

// ### sim/tb.sv
// Self-checking bench for the cam output option logic
`timescale 1ns/1ns
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin miscompares++; $display("ERROR %0t got %h want %h", $time, (a), (b)); end end
module tb;
	localparam int NOUT = 24;
	logic			clock, rstn, inc_step, count_clear, preset_select_input, cam_we;
	logic			clear_all, preset_we, program_unlock, brake_cmd, esc_key, enc_valid, pw_enter;
	logic			coarse, dir_negative, write_reject, store_full, brake_flash, run_relay;
	logic [15:0]		enc_pos, speed, preset_value, position, brake_angle, tgt, pw_value;
	logic [23:0]		ser_pos;
	logic [7:0]		lock_count, cam_idx, error_code;
	logic [6:0]		fault_weight_step, brake_max_angle;
	logic [NOUT-1:0]	cam_out, delay_compensation, direct_compensation;
	logic [31:0]		seed;
	col_pkg::col_opt_t	opt;
	col_pkg::col_cam_t	cam_data;
	int			miscompares, cmp_count;
	logic [15:0]	dt [5] = '{16'd100, 16'd200, 16'd199, 16'd99, 16'd100};
	logic		de [5] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1};
	logic [7:0]	li [5] = '{8'd20, 8'd24, 8'd20, 8'd5, 8'd5};
	logic		lu [5] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
	logic [15:0]	lo [5] = '{16'd10, 16'd10, 16'd300, 16'd500, 16'd500};
	logic [15:0]	lf [5] = '{16'd20, 16'd20, 16'd310, 16'd500, 16'd0};
	logic		lt [5] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
	logic		lr [5] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1};

	col_cam_output #(.NUM_OUT(NOUT), .CYC_PER_MS(4)) u_dut (.clock, .rstn, .opt, .lock_count,
		.fault_weight_step, .timebase_ms(16'h0001), .brake_max_angle, .enc_valid, .enc_pos,
		.ser_pos, .inc_step, .inc_down(1'b0), .count_clear, .preset_select_input, .speed,
		.cam_we, .cam_idx, .cam_data, .clear_all, .preset_we, .preset_value, .program_unlock,
		.pw_enter, .pw_value, .brake_cmd, .esc_key, .cam_out,
		.delay_compensation, .direct_compensation, .position, .dir_negative, .error_code,
		.write_reject, .store_full, .brake_angle, .brake_flash, .run_relay);
	col_enc_model u_enc (.clock, .rstn, .target(tgt), .coarse, .enc_valid, .enc_pos);

	initial
	begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end

	task automatic tick(input int n);
		repeat (n) @(negedge clock);
	endtask
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic [7:0] spd_show(input logic [15:0] s);
		return (s > 16'h00ff) ? 8'hff : s[7:0];
	endfunction
	function automatic col_pkg::col_cam_t mk(input logic [15:0] a, b,
		input col_pkg::col_dir_t d, input logic t);
		return '{a, b, d, t};
	endfunction
	task automatic cam_wr(input logic [7:0] i, input col_pkg::col_cam_t d, output logic rej);
		cam_idx = i;
		cam_data = d;
		cam_we = 1'b1;
		tick(1);
		cam_we = 1'b0;
		rej = write_reject;
		tick(1);
	endtask
	task automatic go(input logic [15:0] t);
		int n;
		tgt = t;
		n = 0;
		while (position !== t && n < 3000)
		begin
			tick(1);
			n++;
		end
		tick(4);
		`CHK(position, t)
	endtask
	task automatic clr(input logic s, input logic [15:0] e);
		preset_select_input = s;
		count_clear = 1'b1;
		tick(1);
		count_clear = 1'b0;
		tick(3);
		`CHK(position, e)
	endtask
	task automatic wrap_up();
		if (miscompares == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// Whole sequence needs about 3k cycles
	initial
	begin
		#400000;
		miscompares++;
		wrap_up();
	end

	initial
	begin
		int i, k;
		logic rej;
		logic [15:0] p0;
		seed = 32'd49;
		{rstn, inc_step, count_clear, preset_select_input, cam_we, clear_all} = '0;
		{preset_we, program_unlock, brake_cmd, esc_key, coarse, pw_enter} = '0;
		{speed, preset_value, tgt, ser_pos, cam_idx, cam_data, opt, pw_value} = '0;
		lock_count = 8'd8;
		fault_weight_step = 7'd1;
		brake_max_angle = 7'd5;
		tick(3);
		rstn = 1'b1;
		opt.fast_compensation_option = 1'b1;
		tick(4);
		`CHK(direct_compensation, 24'h0000ff)
		opt.fast_compensation_option = 1'b0;
		opt.speed_display = 1'b1;
		for (i = 0; i < 12; i++)
		begin
			speed = (i == 0) ? 16'h00ff : (i == 1) ? 16'h0100 : (i == 2) ? 16'h0 : 16'(xs());
			ser_pos = seed[23:0];
			tick(4);
			`CHK(cam_out[NOUT-1 -: 8], spd_show(speed))
		end
		opt.speed_display = 1'b0;
		speed = 16'h0000;
		cam_wr(8'd0, mk(16'd100, 16'd200, col_pkg::COL_DIR_POS, 1'b0), rej);
		for (i = 0; i < 5; i++)
		begin
			go(dt[i]);
			`CHK(cam_out[0], de[i])
			`CHK(dir_negative, (i == 2 || i == 3))
		end
		cam_wr(8'd1, mk(16'd150, 16'd250, col_pkg::COL_DIR_NEG, 1'b0), rej);
		go(16'd160);
		`CHK(cam_out[1], 1'b0)
		cam_wr(8'd2, mk(16'd150, 16'd250, col_pkg::COL_DIR_BOTH, 1'b0), rej);
		tick(4);
		`CHK(cam_out[2:1], 2'b11)
		for (i = 0; i < 5; i++)
		begin
			program_unlock = lu[i];
			cam_wr(li[i], mk(lo[i], lf[i], col_pkg::COL_DIR_BOTH, lt[i]), rej);
			`CHK(rej, lr[i])
			if (i == 3)
				`CHK(error_code, col_pkg::ERR_TIME_CAM)
		end
		opt.password_lock_option = 1'b1;
		program_unlock = 1'b1;
		cam_wr(8'd21, mk(16'd1, 16'd2, col_pkg::COL_DIR_BOTH, 1'b0), rej);
		`CHK(rej, 1'b1)
		pw_value = col_pkg::PASSWORD;
		pw_enter = 1'b1;
		tick(1);
		pw_enter = 1'b0;
		cam_wr(8'd21, mk(16'd1, 16'd2, col_pkg::COL_DIR_BOTH, 1'b0), rej);
		`CHK(rej, 1'b0)
		opt.password_lock_option = 1'b0;
		program_unlock = 1'b0;
		cam_wr(8'd4, mk(16'd170, 16'd5, col_pkg::COL_DIR_BOTH, 1'b1), rej);
		`CHK(rej, 1'b0)
		go(16'd170);
		`CHK(cam_out[4], 1'b1)
		`CHK(delay_compensation[4], 1'b0)
		tick(30);
		`CHK(cam_out[4], 1'b0)
		opt.brake_angle_option = 1'b1;
		for (k = 0; k < 2; k++)
		begin
			brake_max_angle = (k == 1) ? 7'd99 : 7'd5;
			speed = 16'd100;
			brake_cmd = 1'b1;
			tick(2);
			go(position + 16'd10);
			speed = 16'h0000;
			tick(4);
			`CHK(brake_angle, 16'd10)
			`CHK(brake_flash, 1'b1)
			`CHK(error_code, (k == 1) ? col_pkg::ERR_NONE : col_pkg::ERR_BRAKE)
			`CHK(run_relay, (k == 1))
			esc_key = 1'b1;
			tick(1);
			esc_key = 1'b0;
			brake_cmd = 1'b0;
			tick(3);
			`CHK(run_relay, 1'b1)
			`CHK(error_code, col_pkg::ERR_NONE)
		end
		opt.brake_angle_option = 1'b0;
		clear_all = 1'b1;
		tick(1);
		clear_all = 1'b0;
		tick(1);
		for (i = 0; i < 1000; i++)
			cam_wr(8'(i % 16), mk(16'd0, 16'd1, col_pkg::COL_DIR_BOTH, 1'b0), rej);
		`CHK(store_full, 1'b1)
		cam_wr(8'd0, mk(16'd0, 16'd1, col_pkg::COL_DIR_BOTH, 1'b0), rej);
		`CHK(rej, 1'b1)
		opt.inc_mode = 1'b1;
		opt.preset_on_clear_option = 1'b1;
		clr(1'b1, 16'h0000);
		repeat (5)
		begin
			inc_step = 1'b1;
			tick(1);
			inc_step = 1'b0;
			tick(1);
		end
		clr(1'b0, 16'h0000);
		preset_value = 16'h1234;
		preset_we = 1'b1;
		tick(1);
		preset_we = 1'b0;
		clr(1'b1, 16'h1234);
		clr(1'b0, 16'h0000);
		opt.prog_ctrl_mode = 1'b1;
		p0 = position;
		tick(40);
		`CHK(position - p0, 16'd10)
		opt = '0;
		fault_weight_step = 7'd127;
		coarse = 1'b1;
		go(tgt + 16'd40);
		`CHK(error_code, col_pkg::ERR_NONE)
		opt.strict_encoder_check_option = 1'b1;
		go(tgt + 16'd10);
		`CHK(error_code, col_pkg::ERR_ENCODER)
		opt.wide_serial_encoder_option = 1'b1;
		ser_pos = 24'hfed123;
		tick(4);
		`CHK(position, 16'h0123)
		wrap_up();
	end
endmodule
